/* File: hw/hbgs_sequencer.sv */
/*
 Gate-drive sequencer of a time-delayed hysteretic buck controller.
 Assumes comparator, disable and supply-level inputs are asynchronous
 pins; gate outputs feed external half-bridge drivers.
*/
// Contract
// (R01) After power-up, low gate high for hold
// (R02) Feedback low keeps high gate on
// (R03) Feedback high: high off, gap, low on
// (R04) Feedback low: high on, low off later
// (R05) Shoot-through gap between gate transitions; watchdog refresh and disable drop high and raise low on the same edge
// (R06) Watchdog forces refresh after 20 us on
// (R07) Refresh lasts 1 us, then watchdog restarts
// (R08) Disable low means normal regulation
// (R09) Disable high: high gate low, low high
// (R10) Dimming source uses 120 Hz to 5 kHz
// (R11) Enabled interval at least ten on-times
// (R12) Lockout holds both gates low
// (R13) Glitch filter on comparator result
// (R14) Lockout exit and entry use hysteresis
// (R15) Hold, delays, gap, filter are parameters
// (R16) Lockout exit restarts hold; disable cancels refresh
`timescale 1ns/10ps
`default_nettype none

module hbgs_sequencer
  import hbgs_pkg::*;
#(
  parameter int unsigned BOOT_HOLD_CYC = BOOT_HOLD_DEF, // [R15]
  parameter int unsigned ON_DLY_CYC    = ON_DLY_DEF,
  parameter int unsigned OFF_DLY_CYC   = OFF_DLY_DEF,
  parameter int unsigned GAP_CYCLES    = GAP_CYC,
  parameter int unsigned FILT_CYC      = FILT_DEF,
  parameter int unsigned WDOG_CYCLES   = WDOG_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Analog-side status pins
  input  wire logic feedback_above,
  input  wire logic disable_input,
  input  wire logic supply_above_on,
  input  wire logic supply_above_off,
  // Gate drive
  output logic      high_side_gate,
  output logic      low_side_gate,
  // Status
  output logic      supply_lockout
);

  typedef struct packed {
    logic [1:0]       fb_sync;
    logic [1:0]       dis_sync;
    logic [1:0]       on_sync;
    logic [1:0]       off_sync;
    logic             fb_filt;
    logic [CNT_W-1:0] filt_cnt;
    logic             locked;
    hbgs_state_type   state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic             hi;
    logic             lo;
  } hbgs_regs_type;

  hbgs_regs_type s_r;
  hbgs_regs_type s_nxt;

  // Cycle-count parameter narrowed to the counter width
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.fb_sync  = {s_r.fb_sync[0], feedback_above};
    s_nxt.dis_sync = {s_r.dis_sync[0], disable_input};
    s_nxt.on_sync  = {s_r.on_sync[0], supply_above_on};
    s_nxt.off_sync = {s_r.off_sync[0], supply_above_off};

    // Result must hold steady for FILT_CYC cycles before it is taken
    if (s_r.fb_sync[1] == s_r.fb_filt) begin
      s_nxt.filt_cnt = '0;
    end else if (s_r.filt_cnt >= cyc(FILT_CYC) - 16'h0001) begin
      s_nxt.fb_filt  = s_r.fb_sync[1]; // [R13]
      s_nxt.filt_cnt = '0;
    end else begin
      s_nxt.filt_cnt = s_r.filt_cnt + 16'h0001;
    end

    // Leave on upper level, enter only below lower level
    if (s_r.locked && s_r.on_sync[1]) begin
      s_nxt.locked = 1'b0; // [R14]
    end else if (!s_r.locked && !s_r.off_sync[1]) begin
      s_nxt.locked = 1'b1; // [R14]
    end

    s_nxt.cnt = s_r.cnt + 16'h0001;
    // Watchdog runs only while the high gate is on
    s_nxt.wd_cnt = s_r.hi ? s_r.wd_cnt + 16'h0001 : 16'h0000;

    case (s_r.state)
      ST_LOCKOUT: begin
        s_nxt.hi = 1'b0; // [R12]
        s_nxt.lo = 1'b0; // [R12]
        s_nxt.cnt = '0;
        if (!s_r.locked) begin
          s_nxt.state = ST_BOOT; // [R16]
        end
      end
      ST_BOOT: begin
        s_nxt.hi = 1'b0; // [R01]
        s_nxt.lo = 1'b1; // [R01]
        if (s_r.cnt >= cyc(BOOT_HOLD_CYC) - 16'h0001) begin
          s_nxt.state = ST_LOW;
          s_nxt.cnt   = '0;
        end
      end
      ST_LOW: begin
        s_nxt.hi = 1'b0;
        s_nxt.lo = 1'b1;
        s_nxt.cnt = '0;
        if (!s_r.fb_filt) begin
          s_nxt.state = ST_LO_OFF; // [R04]
        end
      end
      ST_LO_OFF: begin
        // High gate on after on-delay, low stays until on-delay plus gap.
        // Brief overlap follows the documented order; low-side is the diode path.
        if (s_r.fb_filt) begin
          s_nxt.state = ST_LOW;
          s_nxt.hi    = 1'b0;
          s_nxt.lo    = 1'b1;
          s_nxt.cnt   = '0;
        end else begin
          if (s_r.cnt >= cyc(ON_DLY_CYC) - 16'h0001) begin
            s_nxt.hi = 1'b1; // [R04]
          end
          if (s_r.cnt >= cyc(ON_DLY_CYC + GAP_CYCLES) - 16'h0001) begin
            s_nxt.lo    = 1'b0; // [R04] [R05]
            s_nxt.state = ST_HIGH;
            s_nxt.cnt   = '0;
          end
        end
      end
      ST_HIGH: begin
        s_nxt.hi = 1'b1; // [R02]
        s_nxt.lo = 1'b0;
        s_nxt.cnt = '0;
        if (s_r.fb_filt) begin
          s_nxt.state = ST_HI_OFF; // [R03]
        end else if (s_r.wd_cnt >= cyc(WDOG_CYCLES) - 16'h0001) begin
          s_nxt.state = ST_REFRESH; // [R06]
          s_nxt.hi    = 1'b0;
          s_nxt.lo    = 1'b1;
        end
      end
      ST_HI_OFF: begin
        if (s_r.cnt >= cyc(OFF_DLY_CYC) - 16'h0001) begin
          s_nxt.hi    = 1'b0; // [R03]
          s_nxt.state = ST_GAP_LO;
          s_nxt.cnt   = '0;
        end
      end
      ST_GAP_LO: begin
        s_nxt.hi = 1'b0;
        if (s_r.cnt >= cyc(GAP_CYCLES) - 16'h0001) begin
          s_nxt.lo    = 1'b1; // [R03] [R05]
          s_nxt.state = ST_LOW;
          s_nxt.cnt   = '0;
        end
      end
      ST_REFRESH: begin
        s_nxt.hi = 1'b0; // [R06]
        s_nxt.lo = 1'b1;
        if (s_r.cnt >= cyc(REFRESH_CYC) - 16'h0001) begin
          s_nxt.state = ST_LOW; // [R07]
          s_nxt.cnt   = '0;
        end
      end
      default: begin
        s_nxt.state = ST_LOCKOUT;
      end
    endcase

    // Disable overrides regulation and cancels any refresh in progress
    if (s_r.dis_sync[1] && s_r.state != ST_LOCKOUT && s_r.state != ST_BOOT) begin
      s_nxt.state = ST_LOW; // [R09] [R16]
      s_nxt.hi    = 1'b0;   // [R09]
      s_nxt.lo    = 1'b1;   // [R09]
      s_nxt.cnt   = '0;
    end

    // Lockout has top priority, and re-entry restarts the hold
    // Next-state flag, so the gates drop on the same edge the status rises
    if (s_nxt.locked) begin
      s_nxt.state = ST_LOCKOUT; // [R12] [R16]
      s_nxt.hi    = 1'b0;
      s_nxt.lo    = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r        <= '0;
      s_r.locked <= 1'b1;
      s_r.state  <= ST_LOCKOUT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Regulation needs disable low; [R08] handled by the override gate above
  assign high_side_gate = s_r.hi;
  assign low_side_gate  = s_r.lo;
  assign supply_lockout = s_r.locked;

endmodule

`default_nettype wire

/* File: shared/hbgs_pkg.sv */
/*
 Constants for the hysteretic buck gate sequencer: state codes and timing
 counts. Assumes a 10 MHz core clock (100 ns period).
*/
package hbgs_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 100;

  // Documented times, in their own units
  localparam int unsigned GAP_NS         = 140;
  localparam int unsigned WDOG_US        = 20;
  localparam int unsigned REFRESH_US     = 1;

  // Cycle counts; least times round up, none below one cycle
  localparam int unsigned GAP_CYC_RAW    = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC        = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
  localparam int unsigned WDOG_CYC       = (WDOG_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CYC    = (REFRESH_US * 1000) / CLK_PERIOD_NS;

  // Defaults of cycle-count parameters whose figures are not documented
  localparam int unsigned BOOT_HOLD_DEF  = 100;
  localparam int unsigned ON_DLY_DEF     = 3;
  localparam int unsigned OFF_DLY_DEF    = 2;
  localparam int unsigned FILT_DEF       = 2;

  localparam int unsigned CNT_W          = 16;

  typedef enum logic [2:0] {
    ST_LOCKOUT = 3'b000,
    ST_BOOT    = 3'b001,
    ST_HIGH    = 3'b010,
    ST_HI_OFF  = 3'b011,
    ST_GAP_LO  = 3'b100,
    ST_LOW     = 3'b101,
    ST_LO_OFF  = 3'b110,
    ST_REFRESH = 3'b111
  } hbgs_state_type;

endpackage

/* File: test/hbgs_monitor.sv */
/* Checker on the gate sequencer pins.
 Bound into every hbgs_sequencer; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module hbgs_monitor #(parameter int unsigned WDOG_CYCLES = 200) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sequencer pins
  input wire logic disable_input,
  input wire logic supply_above_off,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic supply_lockout
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] on_cnt_r;
  always_ff @(posedge core_clk) on_cnt_r <= high_side_gate ? on_cnt_r + 16'h1 : 16'h0;
  a_lock_gates_low: assert property (supply_lockout |-> !high_side_gate && !low_side_gate)
    else $error("gate on in lockout");
  a_lock_entry: assert property (!supply_above_off [*5] |-> supply_lockout)
    else $error("no lockout");
  a_lock_hyst: assert property (supply_above_off [*4] ##0 !supply_lockout |=> !supply_lockout)
    else $error("lockout without low supply");
  a_boot_hold: assert property ($fell(supply_lockout) |-> ##2 (!high_side_gate && low_side_gate) [*3])
    else $error("boot hold broken");
  a_disable_hold: assert property ((disable_input && !supply_lockout) [*6] |-> !high_side_gate && low_side_gate)
    else $error("disable ignored");
  a_wdog_bound: assert property (on_cnt_r <= WDOG_CYCLES + 1)
    else $error("high gate on too long");
  a_gap_lo_rise: assert property ($rose(low_side_gate) |-> !high_side_gate)
    else $error("low gate rose with high on");
  a_hi_rise_lo: assert property ($rose(high_side_gate) |-> low_side_gate)
    else $error("low gate off before high on");
endmodule
bind hbgs_sequencer hbgs_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) hbgs_monitor_inst (
  .core_clk(core_clk), .rst(rst), .disable_input(disable_input),
  .supply_above_off(supply_above_off), .high_side_gate(high_side_gate),
  .low_side_gate(low_side_gate), .supply_lockout(supply_lockout));
`default_nettype wire

/* File: test/hbgs_bridge_model.sv */
/* Half-bridge and inductor: current climbs while the high gate is on.
 Assumes gates from the sequencer; feeds its comparator pin. */
`timescale 1ns/10ps
`default_nettype none
module hbgs_bridge_model (
  // Clock
  input wire logic core_clk,
  // Gates
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  // Comparator
  output logic     feedback_above
);
  int unsigned amps_r = 0;
  // Fast rise, slow fall: on-times stay well inside the watchdog
  always @(posedge core_clk) begin
    if (high_side_gate && amps_r < 40) amps_r <= amps_r + 3;
    else if (low_side_gate && amps_r > 0) amps_r <= amps_r - 1;
  end
  assign feedback_above = amps_r > 20;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
/* Bench for the gate sequencer with the bridge model on its gates.
 Assumes short boot hold and watchdog counts chosen here. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: mismatch", $time); end end
module tb_top
  import hbgs_pkg::*;
;
  localparam int WD = 20;
  logic core_clk = 1'b0, rst = 1'b1, fb_drv = 1'b0, use_model = 1'b0;
  logic dis = 1'b0, sup_on = 1'b0, sup_off = 1'b0;
  logic fb_model, fb_pin, hi, lo, lock;
  logic [2:0] pins;
  int fail_count = 0, compares = 0, n, t;
  assign fb_pin = use_model ? fb_model : fb_drv;
  assign pins = {lock, hi, lo};
  always #50 core_clk = ~core_clk;
  hbgs_sequencer #(.BOOT_HOLD_CYC(5), .WDOG_CYCLES(WD)) hbgs_sequencer_inst (
    .core_clk(core_clk), .rst(rst), .feedback_above(fb_pin), .disable_input(dis),
    .supply_above_on(sup_on), .supply_above_off(sup_off), .high_side_gate(hi),
    .low_side_gate(lo), .supply_lockout(lock));
  hbgs_bridge_model hbgs_bridge_model_inst (.core_clk(core_clk), .high_side_gate(hi),
    .low_side_gate(lo), .feedback_above(fb_model));
  task automatic close_out;
    $display("Compares %0d, errors %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Bit 2 lockout, 1 high gate, 0 low gate
  task automatic wait_lvl(input int b, input logic v);
    n = 0;
    while (pins[b] !== v) begin
      tick(1);
      n++;
      if (n > 500) begin
        fail_count++;
        close_out();
      end
    end
  endtask
  initial begin
    void'($urandom(32'hD74547E9));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    `CHK(pins, 3'h4)
    @(posedge core_clk) sup_on <= 1'b1;
    sup_off <= 1'b1;
    wait_lvl(2, 1'b0);
    tick(2);
    `CHK(pins, 3'h1)
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    `CHK(n inside {[WD:WD + 1]}, 1'b1)
    tick(2);
    `CHK(pins[1:0], 2'h1)
    wait_lvl(1, 1'b1);
    `CHK(n >= REFRESH_CYC - 2, 1'b1)
    @(posedge core_clk) fb_drv <= 1'b1;
    @(posedge core_clk) fb_drv <= 1'b0;
    tick(8);
    `CHK(hi, 1'b1)
    @(posedge core_clk) use_model <= 1'b1;
    repeat (4) begin
      // Dimming pulses; enabled spans far above the on-time
      // Disabled long enough for the model current to drain fully
      t = 45 + $urandom_range(30);
      @(posedge core_clk) dis <= 1'b1;
      tick(t);
      `CHK(pins[1:0], 2'h1)
      @(posedge core_clk) dis <= 1'b0;
      wait_lvl(1, 1'b1);
      `CHK(n inside {[ON_DLY_DEF + 2:ON_DLY_DEF + 4]}, 1'b1)
      tick(120);
    end
    repeat (4) begin
      wait_lvl(1, 1'b1);
      wait_lvl(1, 1'b0);
      wait_lvl(0, 1'b1);
      `CHK(n inside {[GAP_CYC:GAP_CYC + 1]}, 1'b1)
    end
    @(posedge core_clk) sup_on <= 1'b0;
    tick(10);
    `CHK(lock, 1'b0)
    @(posedge core_clk) sup_off <= 1'b0;
    wait_lvl(2, 1'b1);
    `CHK(pins, 3'h4)
    @(posedge core_clk) sup_off <= 1'b1;
    tick(10);
    `CHK(lock, 1'b1)
    @(posedge core_clk) sup_on <= 1'b1;
    wait_lvl(2, 1'b0);
    tick(2);
    `CHK(pins, 3'h1)
    close_out();
  end
endmodule
`default_nettype wire
